//--- logic/bwd_pkg.sv
package bwd_pkg;

  // Register byte offsets
  localparam logic [11:0] BWD_CTRL_OFS   = 12'h000;
  localparam logic [11:0] BWD_STAT_OFS   = 12'h004;
  localparam logic [11:0] BWD_IRQST_OFS  = 12'h008;
  localparam logic [11:0] BWD_IRQCLR_OFS = 12'h00C;
  localparam logic [11:0] BWD_IRQEN_OFS  = 12'h010;
  localparam logic [11:0] BWD_ACK_OFS    = 12'h014;

  // Control field positions
  localparam int BWD_CTRL_BUSMON  = 0;
  localparam int BWD_CTRL_PLCMON  = 1;
  localparam int BWD_CTRL_AUTOACK = 2;
  localparam int BWD_CTRL_SRCSEL  = 3;
  localparam int BWD_CTRL_W       = 4;
  localparam logic [BWD_CTRL_W-1:0] BWD_CTRL_RST = 4'h3;

  // Status field positions
  localparam int BWD_ST_BUSOK   = 0;
  localparam int BWD_ST_PLCRUN  = 1;
  localparam int BWD_ST_BUSFLT  = 2;
  localparam int BWD_ST_PLCFLT  = 3;
  localparam int BWD_ST_REMOTE  = 4;
  localparam int BWD_ST_W       = 5;

  // Interrupt event positions
  localparam int BWD_EV_BUSFLT  = 0;
  localparam int BWD_EV_PLCFLT  = 1;
  localparam int BWD_EV_BUSLOST = 2;
  localparam int BWD_EV_PLCSTOP = 3;
  localparam int BWD_EV_W       = 4;

  // Acknowledge register bit
  localparam int BWD_ACK_BIT = 0;

  // Controller states reported by the bus master
  typedef enum logic [1:0] {
    BWD_MST_RUN   = 2'b00,
    BWD_MST_CLEAR = 2'b01,
    BWD_MST_HOLD  = 2'b10,
    BWD_MST_OFF   = 2'b11
  } bwd_mst_t;

  // Fault latch states
  typedef enum logic [0:0] {
    BWD_FLT_IDLE = 1'b0,
    BWD_FLT_SET  = 1'b1
  } bwd_flt_t;

  // Link side inputs
  typedef struct packed {
    logic     cyclicActive;
    bwd_mst_t masterState;
    logic     rxBit07;
    logic     remoteSelectorBitA;
    logic     remoteSelectorBitB;
  } bwd_link_t;

  // APB request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bwd_apb_req_t;

endpackage

//--- logic/bwd_watchdog.sv
`timescale 1ns/1ns
// What this block does
// - Bus fault when bus supervision on, remote mode, cyclic exchange stops
// - Bus-healthy flag always readable, one while cyclic exchange runs
// - Controller fault when supervision on, remote, master in clear/hold
// - Controller-running flag always readable, zero in clear state
// - With receive bit 0.7 as source, running state comes from it alone
// - Bus supervision on after reset; disabled gives no fault, flag kept
// - Controller supervision on after reset; disabled gives no fault
// - Manual or automatic acknowledge selectable, manual after reset
// - Each fault response is fault or deactivated only
// - Supervision input may be any internal signal, e.g. bus control bit
module bwd_watchdog (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Link side
  input  wire bwd_pkg::bwd_link_t   link,
  input  wire logic                 monitorSignal,
  // APB slave
  input  wire bwd_pkg::bwd_apb_req_t apbReq,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Status and interrupt
  output logic                      busFault,
  output logic                      plcFault,
  output logic                      busOk,
  output logic                      plcRun,
  output logic                      irq
);
  import bwd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Register state
  logic [BWD_CTRL_W-1:0]  ctrl_reg;
  logic [BWD_EV_W-1:0]    irqSt_reg;
  logic [BWD_EV_W-1:0]    irqEn_reg;
  bwd_flt_t               busFlt_reg;
  bwd_flt_t               plcFlt_reg;
  logic                   busOk_reg;
  logic                   plcRun_reg;
  logic [31:0]            prdata_reg;
  logic                   pready_reg;
  logic                   pslverr_reg;
  logic                   irq_reg;

  //////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state, writes land on the completing edge so a
  // register never changes before the master has seen pready
  wire access   = apbReq.psel & apbReq.penable & ~pready_reg;
  wire complete = apbReq.psel & apbReq.penable & pready_reg;
  wire wrAcc    = complete & apbReq.pwrite;
  wire hitCtrl  = apbReq.paddr == BWD_CTRL_OFS;
  wire hitStat  = apbReq.paddr == BWD_STAT_OFS;
  wire hitIrqSt = apbReq.paddr == BWD_IRQST_OFS;
  wire hitClr   = apbReq.paddr == BWD_IRQCLR_OFS;
  wire hitEn    = apbReq.paddr == BWD_IRQEN_OFS;
  wire hitAck   = apbReq.paddr == BWD_ACK_OFS;
  wire mapped   = hitCtrl | hitStat | hitIrqSt | hitClr | hitEn | hitAck;
  wire ackPulse = wrAcc & hitAck & apbReq.pwdata[BWD_ACK_BIT];
  wire [BWD_EV_W-1:0] clrMask =
    (wrAcc & hitClr) ? apbReq.pwdata[BWD_EV_W-1:0] : '0;

  //////////////////////////////////////////////////////////////////////////
  // Supervision conditions
  wire busMonOn  = ctrl_reg[BWD_CTRL_BUSMON];
  wire plcMonOn  = ctrl_reg[BWD_CTRL_PLCMON];
  wire autoAck   = ctrl_reg[BWD_CTRL_AUTOACK];
  wire useSignal = ctrl_reg[BWD_CTRL_SRCSEL];
  wire remote    = link.remoteSelectorBitA & link.remoteSelectorBitB;
  // Detection relies on the master's slave watchdog dropping cyclicActive
  wire busAlive  = link.cyclicActive;
  // Signal source overrides master state when selected
  wire mstRun    = busAlive & (link.masterState == BWD_MST_RUN);
  wire plcAlive  = useSignal ? monitorSignal : mstRun;
  wire busCause  = busMonOn & remote & ~busAlive;
  wire plcCause  = plcMonOn & remote & ~plcAlive;

  // Fault clears: manual needs acknowledge, auto needs cause gone
  wire busClr = ~busCause & (autoAck | ackPulse);
  wire plcClr = ~plcCause & (autoAck | ackPulse);

  bwd_flt_t busFlt_next;
  bwd_flt_t plcFlt_next;
  always_comb begin
    busFlt_next = busFlt_reg;
    case (busFlt_reg)
      BWD_FLT_IDLE: if (busCause) busFlt_next = BWD_FLT_SET;
      BWD_FLT_SET:  if (busClr) busFlt_next = BWD_FLT_IDLE;
      default:      busFlt_next = BWD_FLT_IDLE;
    endcase
  end
  always_comb begin
    plcFlt_next = plcFlt_reg;
    case (plcFlt_reg)
      BWD_FLT_IDLE: if (plcCause) plcFlt_next = BWD_FLT_SET;
      BWD_FLT_SET:  if (plcClr) plcFlt_next = BWD_FLT_IDLE;
      default:      plcFlt_next = BWD_FLT_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt events: fault rising edges and status drops
  wire [BWD_EV_W-1:0] events;
  assign events[BWD_EV_BUSFLT]  = busFlt_next == BWD_FLT_SET &&
                                  busFlt_reg == BWD_FLT_IDLE;
  assign events[BWD_EV_PLCFLT]  = plcFlt_next == BWD_FLT_SET &&
                                  plcFlt_reg == BWD_FLT_IDLE;
  assign events[BWD_EV_BUSLOST] = busOk_reg & ~busAlive;
  assign events[BWD_EV_PLCSTOP] = plcRun_reg & ~plcAlive;
  // Set wins over a simultaneous clear
  wire [BWD_EV_W-1:0] irqSt_next = (irqSt_reg & ~clrMask) | events;

  //////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [BWD_ST_W-1:0] statWord = {remote, plcFlt_reg == BWD_FLT_SET,
                                  busFlt_reg == BWD_FLT_SET,
                                  plcRun_reg, busOk_reg};
  wire [31:0] rdMux =
    hitCtrl  ? {{(32-BWD_CTRL_W){1'b0}}, ctrl_reg} :
    hitStat  ? {{(32-BWD_ST_W){1'b0}}, statWord} :
    hitIrqSt ? {{(32-BWD_EV_W){1'b0}}, irqSt_reg} :
    hitEn    ? {{(32-BWD_EV_W){1'b0}}, irqEn_reg} : 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////
  // Sequential
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= BWD_CTRL_RST;
      irqEn_reg <= '0;
    end else if (wrAcc & hitCtrl) begin
      ctrl_reg <= apbReq.pwdata[BWD_CTRL_W-1:0];
    end else if (wrAcc & hitEn) begin
      irqEn_reg <= apbReq.pwdata[BWD_EV_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busFlt_reg <= BWD_FLT_IDLE;
      plcFlt_reg <= BWD_FLT_IDLE;
      busOk_reg  <= 1'b0;
      plcRun_reg <= 1'b0;
      irqSt_reg  <= '0;
      irq_reg    <= 1'b0;
    end else begin
      busFlt_reg <= busFlt_next;
      plcFlt_reg <= plcFlt_next;
      busOk_reg  <= busAlive;
      plcRun_reg <= plcAlive;
      irqSt_reg  <= irqSt_next;
      irq_reg    <= |(irqSt_next & irqEn_reg);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access & ~mapped;
      prdata_reg  <= (access & ~apbReq.pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign busFault = busFlt_reg == BWD_FLT_SET;
  assign plcFault = plcFlt_reg == BWD_FLT_SET;
  assign busOk    = busOk_reg;
  assign plcRun   = plcRun_reg;
  assign irq      = irq_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  bus_fault_set_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    busCause |=> busFault)
    else $error("bus fault not raised");
  bus_stop_fault_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (busMonOn && link.remoteSelectorBitA && link.remoteSelectorBitB &&
     !link.cyclicActive) |=> busFault)
    else $error("bus fault missed on stopped exchange");
  bus_alive_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (link.cyclicActive && !busFault) |=> !busFault)
    else $error("bus fault while exchange runs");
  bus_local_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!remote && !busFault) |=> !busFault)
    else $error("bus fault outside remote mode");
  bus_ok_follow_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    link.cyclicActive |=> busOk)
    else $error("busOk not set");
  bus_ok_drop_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    !link.cyclicActive |=> !busOk)
    else $error("busOk set without exchange");
  bus_mon_off_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!busMonOn && !busFault) |=> !busFault)
    else $error("bus fault while off");

  // Controller supervision
  plc_fault_set_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    plcCause |=> plcFault)
    else $error("plc fault not raised");
  plc_clear_flt_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (plcMonOn && remote && !useSignal &&
     link.masterState == BWD_MST_CLEAR) |=> plcFault)
    else $error("plc fault missed in clear state");
  plc_hold_stop_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (plcMonOn && remote && !useSignal &&
     link.masterState == BWD_MST_HOLD) |=> plcFault)
    else $error("plc fault missed in hold state");
  plc_clear_run_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!useSignal && link.masterState == BWD_MST_CLEAR) |=> !plcRun)
    else $error("plcRun high in clear");
  plc_run_mst_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!useSignal && link.cyclicActive &&
     link.masterState == BWD_MST_RUN) |=> plcRun)
    else $error("plcRun low while master runs");
  plc_bit_source_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    useSignal |=> plcRun == $past(monitorSignal))
    else $error("plcRun not from signal");
  plc_bit_only_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (useSignal && monitorSignal && !plcFault) |=> !plcFault)
    else $error("plc fault while signal shows run");
  plc_sig_fault_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (plcMonOn && remote && useSignal && !monitorSignal) |=> plcFault)
    else $error("plc fault missed on signal source");
  plc_mon_off_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!plcMonOn && !plcFault) |=> !plcFault)
    else $error("plc fault while off");

  // Acknowledge and reset defaults
  reset_default_a : assert property (
    @(posedge mclk)
    !rst_n |=> (ctrl_reg == BWD_CTRL_RST && !busFault && !plcFault && !irq))
    else $error("reset defaults wrong");
  manual_hold_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (busFault && !autoAck && !ackPulse) |=> busFault)
    else $error("bus fault cleared without ack");
  manual_plc_hold_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (plcFault && !autoAck && !ackPulse) |=> plcFault)
    else $error("plc fault cleared without ack");
  auto_clear_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (plcFault && autoAck && !plcCause) |=> !plcFault)
    else $error("plc fault not auto cleared");
  auto_bus_clear_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (busFault && autoAck && !busCause) |=> !busFault)
    else $error("bus fault not auto cleared");
  ack_bus_clear_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (busFault && ackPulse && !busCause) |=> !busFault)
    else $error("bus fault kept after ack");
  ack_plc_clear_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (plcFault && ackPulse && !plcCause) |=> !plcFault)
    else $error("plc fault kept after ack");
  bus_cause_hold_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (busFault && busCause) |=> busFault)
    else $error("bus fault cleared while cause stands");
  plc_cause_hold_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (plcFault && plcCause) |=> plcFault)
    else $error("plc fault cleared while cause stands");

  // Interrupt status and level
  bus_event_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!busFault && busCause) |=> irqSt_reg[BWD_EV_BUSFLT])
    else $error("bus fault event not latched");
  plc_event_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!plcFault && plcCause) |=> irqSt_reg[BWD_EV_PLCFLT])
    else $error("plc fault event not latched");
  bus_lost_ev_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (busOk && !link.cyclicActive) |=> irqSt_reg[BWD_EV_BUSLOST])
    else $error("bus lost event not latched");
  plc_stop_ev_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (plcRun && !plcAlive) |=> irqSt_reg[BWD_EV_PLCSTOP])
    else $error("plc stop event not latched");
  irq_set_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (|(events & irqEn_reg)) |=> irq)
    else $error("irq not raised on enabled event");
  irq_level_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    $stable(irqEn_reg) |-> irq == |(irqSt_reg & irqEn_reg))
    else $error("irq mismatch");

  // Register bus answer
  pready_pulse_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_answer_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    (apbReq.psel && apbReq.penable && !pready) |=> pready)
    else $error("no answer after one wait state");
  read_idle_zero_a : assert property (
    @(posedge mclk) disable iff (!rst_n)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");

endmodule // bwd_watchdog

//--- tb/bwd_master_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module bwd_master_model (
  // Controls from the bench
  input  wire logic          exchOn,
  input  wire logic [1:0]    mstState,
  input  wire logic [1:0]    remoteSel,
  input  wire logic          ctrlBit,
  // Link towards the watchdog
  output bwd_pkg::bwd_link_t link
);
  import bwd_pkg::*;
  // Slave watchdog on, so a stopped exchange shows at once
  assign link.cyclicActive       = exchOn;
  assign link.masterState        = bwd_mst_t'(mstState);
  assign link.rxBit07            = ctrlBit;
  assign link.remoteSelectorBitA = remoteSel[1];
  assign link.remoteSelectorBitB = remoteSel[0];
endmodule // bwd_master_model

//--- tb/tb_bus_and_plc_watchdog.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module tb_bus_and_plc_watchdog;
  import bwd_pkg::*;
  logic         mclk, rst_n, cyc, b7, busOk, plcRun, busFault, plcFault;
  logic         irq, pready, pslverr, er, rn;
  logic [1:0]   st, rem;
  logic [31:0]  prdata, rd;
  bwd_link_t    link;
  bwd_apb_req_t req;
  int           fails, compares, mCtrl, mBus, mPlc, mIrq;

  bwd_master_model u_bwd_master_model (.exchOn(cyc), .mstState(st),
    .remoteSel(rem), .ctrlBit(b7), .link(link));
  // Receive bit 0.7 is wired as the supervision source
  bwd_watchdog u_bwd_watchdog (.mclk(mclk), .rst_n(rst_n), .link(link),
    .monitorSignal(link.rxBit07), .apbReq(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busFault(busFault),
    .plcFault(plcFault), .busOk(busOk), .plcRun(plcRun), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chkBit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: flag %b, model %b", $time, g, e);
    end
  endtask

  task automatic chkWord(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: word %h, model %h", $time, g, e);
    end
  endtask

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Lets inputs settle, then compares outputs and status with the model
  task automatic step(input bit ack);
    logic run;
    int bc, pc;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    run = mCtrl[3] ? b7 : (cyc && st == 2'b00);
    bc = mCtrl[0] && rem == 2'b11 && !cyc;
    pc = mCtrl[1] && rem == 2'b11 && !run;
    mBus = bc | (mBus & !(mCtrl[2] | ack));
    mPlc = pc | (mPlc & !(mCtrl[2] | ack));
    chkBit(busOk, cyc);
    chkBit(plcRun, run);
    chkBit(busFault, mBus[0]);
    chkBit(plcFault, mPlc[0]);
    chkBit(irq, mIrq[0]); // Level follows enabled status
    apb(1'b1, BWD_STAT_OFS, 32'h0);
    apb(1'b0, BWD_STAT_OFS, 32'h0);
    chkWord(rd, {27'h0, rem == 2'b11, mPlc[0], mBus[0], run, cyc});
  endtask

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    results();
  end

  initial begin
    {cyc, b7, st, rem, req} = '0;
    {fails, compares, mBus, mPlc, mIrq} = '0;
    rst_n = 1'b0;
    mCtrl = 3;
    void'($urandom(20354));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, BWD_CTRL_OFS, 32'h0);
    chkWord(rd, 32'h3);
    apb(1'b1, 12'h018, 32'hF);
    chkBit(er, 1'b1); // Unmapped place refused
    apb(1'b0, 12'h018, 32'h0);
    chkWord(rd, 32'h0); // Unmapped place reads zero
    cyc <= 1'b1;
    rem <= 2'b11;
    step(0);
    apb(1'b1, BWD_IRQCLR_OFS, 32'hF);
    apb(1'b1, BWD_IRQEN_OFS, 32'h1);
    cyc <= 1'b0;
    mIrq = 1;
    step(0);
    apb(1'b0, BWD_IRQST_OFS, 32'h0);
    chkWord(rd, 32'hF);
    cyc <= 1'b1;
    apb(1'b1, BWD_IRQCLR_OFS, 32'hF);
    mIrq = 0;
    step(0);
    apb(1'b1, BWD_ACK_OFS, 32'h1);
    step(1);
    apb(1'b1, BWD_IRQEN_OFS, 32'h0);
    repeat (60) begin
      mCtrl = $urandom_range(0, 15);
      apb(1'b1, BWD_CTRL_OFS, mCtrl);
      step(0);
      @(posedge mclk);
      {cyc, b7, st, rem, rn} <= 7'($urandom);
      step(0);
      if (rn) begin
        apb(1'b1, BWD_ACK_OFS, 32'h1);
        step(1);
      end
    end
    results();
  end
endmodule // tb_bus_and_plc_watchdog
